// ### tfrc_consts.vh
`ifndef TFRC_CONSTS_VH
`define TFRC_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define TFRC_ADDR_STEP_FIRST 8'h14
`define TFRC_ADDR_STEP_SECOND 8'h15
`define TFRC_ADDR_CFG_ONE 8'h16
`define TFRC_ADDR_CFG_TWO 8'h17
`define TFRC_ADDR_STEP_MC 8'h18
`define TFRC_ADDR_STEP_SP 8'h19
`define TFRC_ADDR_CPU_ONE 8'h1A
`define TFRC_ADDR_CPU_TWO 8'h1B
`define TFRC_ADDR_CPU_THREE 8'h1C
`define TFRC_ADDR_PART_ID 8'h1D
`define TFRC_ADDR_TERM_HI 8'h1E
`define TFRC_ADDR_TERM_EXT 8'h1F
`define TFRC_ADDR_CPU_ZERO 8'h33

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TFRC_RST_STEP 8'h00
`define TFRC_RST_CFG_ONE 8'h1C
`define TFRC_RST_CFG_TWO 8'h07
`define TFRC_RST_CPU 8'h80
`define TFRC_RST_TERM 10'h000

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define TFRC_CFG1_TMR_LO 0
`define TFRC_CFG1_FULL_LO 2
`define TFRC_CFG1_PUSH_EN 5
`define TFRC_CFG1_SLAVE_EN 6
`define TFRC_CFG1_MASK 8'h7F
`define TFRC_CFG2_MASK 8'h07
`define TFRC_EXT_LO 4

// ------------------------------------------------------------
// Timer pin select codes and duty constants
// ------------------------------------------------------------
`define TFRC_TMR_OFF 2'h0
`define TFRC_TMR_PIN_A 2'h1
`define TFRC_TMR_PIN_B 2'h2
`define TFRC_TMR_PIN_C 2'h3
`define TFRC_DUTY_FULL 8'hFF

// Source order on the temperature buses
`define TFRC_SRC_PUSH 0
`define TFRC_SRC_SLAVE 1
`define TFRC_SRC_MASTER 2
`define TFRC_SRC_CPU 3
`define TFRC_SRC_DIODE 4

`endif

// ### tfrc_pin_sync.v
`include "tfrc_consts.vh"

// Three-stage pin synchroniser; output moves when stages two and three agree
module tfrc_pin_sync
(
  input wire clk_sys,
  input wire srst,
  input wire pinIn,
  output reg pinOut
);

  reg stageOne;
  reg stageTwo;
  reg stageThree;

  // ------------------------------------------------------------
  // Sampling chain
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      stageOne <= 1'b0;
      stageTwo <= 1'b0;
      stageThree <= 1'b0;
      pinOut <= 1'b0;
    end
    else
    begin
      stageOne <= pinIn;
      stageTwo <= stageOne;
      stageThree <= stageTwo;
      if (stageTwo == stageThree)
        pinOut <= stageThree;
    end
  end

endmodule // tfrc_pin_sync

// ### tfrc_overtemp_signal_fan_config.v
`include "tfrc_consts.vh"

// Summary of operation
// - With stepping on and an over-temperature event, a responding fan runs at the first step level.
// - With stepping on and temperature above limit plus step, a responding fan runs at the second step level.
// - The step interval comes from the two step-size registers, not a constant.
// - The two-bit timer pin select disables the timer input at 00 and picks one of three pins otherwise.
// - A per-fan bit chooses full duty (set) or programmed maximum duty (clear) on over-temperature with stepping off.
// - Pushed temperatures raise over-temperature only while the pushed source enable is set.
// - Slave sensor temperatures raise over-temperature only while the slave source enable is set.
// - Each fan reacts to over-temperature only while its own respond bit, at bits zero to two, is set.
// - A low four-bit field holds the step size for master sensor events.
// - A high four-bit field holds the step size for cpu control temperature events.
// - A low four-bit field holds the step size for the diode and local sensor events.
// - A high four-bit field holds the step size for pushed temperature events.
// - Each of the four cpu readings appears as an eight-bit read-only register.
// - The termination voltage register returns the upper eight bits of the conversion.
// - Bits five and four of the extended register return the two low bits of that conversion.
module tfrc_overtemp_signal_fan_config
#(
  parameter PART_ID = 8'h5A // Arbitrary identification value
)
(
  input wire clk_sys,
  input wire srst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  input wire steppingEnable,
  input wire [39:0] srcTemp,
  input wire [39:0] srcLimit,
  input wire [23:0] fanNormalDuty,
  input wire [23:0] fanMaxDuty,
  input wire timerPinA,
  input wire timerPinB,
  input wire timerPinC,
  input wire [31:0] cpuReadings,
  input wire [9:0] termResult,
  input wire termValid,
  output reg [23:0] fanDuty,
  output reg [2:0] fanOverride,
  output reg overtempActive,
  output reg timerInput
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg [7:0] first_step_level;
  reg [7:0] second_step_level;
  reg [7:0] overtempConfigOne;
  reg [7:0] overtempConfigTwo;
  reg [7:0] stepSizeMasterCpu;
  reg [7:0] stepSizeSensorPush;
  reg [31:0] cpuHeld;
  reg [9:0] termHeld;
  reg termFrozen;
  reg [7:0] next_regRdData;

  wire [1:0] timerPinSelect;
  wire [2:0] fanFullSelect;
  wire pushedSourceEnable;
  wire slaveSensorSourceEnable;
  wire [2:0] fanOvertempRespond;
  wire [3:0] masterSensorStepSize;
  wire [3:0] cpuControlStepSize;
  wire [3:0] diodeSensorStepSize;
  wire [3:0] pushedTempStepSize;
  wire syncPinA;
  wire syncPinB;
  wire syncPinC;
  wire [19:0] stepBus;
  wire [4:0] srcEnable;
  wire [4:0] srcOver;
  wire [4:0] srcOverStep;
  wire anyOver;
  wire anyOverStep;

  // Field views of the configuration registers
  assign timerPinSelect = overtempConfigOne[1:0];
  assign fanFullSelect = overtempConfigOne[4:2];
  assign pushedSourceEnable = overtempConfigOne[`TFRC_CFG1_PUSH_EN];
  assign slaveSensorSourceEnable = overtempConfigOne[`TFRC_CFG1_SLAVE_EN];
  assign fanOvertempRespond = overtempConfigTwo[2:0];
  assign masterSensorStepSize = stepSizeMasterCpu[3:0];
  assign cpuControlStepSize = stepSizeMasterCpu[7:4];
  assign diodeSensorStepSize = stepSizeSensorPush[3:0];
  assign pushedTempStepSize = stepSizeSensorPush[7:4];

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      first_step_level <= `TFRC_RST_STEP;
      second_step_level <= `TFRC_RST_STEP;
      overtempConfigOne <= `TFRC_RST_CFG_ONE;
      overtempConfigTwo <= `TFRC_RST_CFG_TWO;
      stepSizeMasterCpu <= `TFRC_RST_STEP;
      stepSizeSensorPush <= `TFRC_RST_STEP;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `TFRC_ADDR_STEP_FIRST:
          first_step_level <= regWrData;
        `TFRC_ADDR_STEP_SECOND:
          second_step_level <= regWrData;
        `TFRC_ADDR_CFG_ONE:
          overtempConfigOne <= regWrData & `TFRC_CFG1_MASK;
        `TFRC_ADDR_CFG_TWO:
          overtempConfigTwo <= regWrData & `TFRC_CFG2_MASK;
        `TFRC_ADDR_STEP_MC:
          stepSizeMasterCpu <= regWrData;
        `TFRC_ADDR_STEP_SP:
          stepSizeSensorPush <= regWrData;
        default:
          first_step_level <= first_step_level;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result capture
  // ------------------------------------------------------------
  // Cpu readings follow their sources
  always @(posedge clk_sys)
  begin
    if (srst)
      cpuHeld <= {4{`TFRC_RST_CPU}};
    else
      cpuHeld <= cpuReadings;
  end

  // Conversion result, frozen between extended and upper byte reads
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      termHeld <= `TFRC_RST_TERM;
      termFrozen <= 1'b0;
    end
    else
    begin
      if (termValid && !termFrozen)
        termHeld <= termResult;
      if (regRead && regAddr == `TFRC_ADDR_TERM_EXT)
        termFrozen <= 1'b1;
      else if (regRead && regAddr == `TFRC_ADDR_TERM_HI)
        termFrozen <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  always @*
  begin
    next_regRdData = 8'h00;
    case (regAddr)
      `TFRC_ADDR_STEP_FIRST:
        next_regRdData = first_step_level;
      `TFRC_ADDR_STEP_SECOND:
        next_regRdData = second_step_level;
      `TFRC_ADDR_CFG_ONE:
        next_regRdData = overtempConfigOne;
      `TFRC_ADDR_CFG_TWO:
        next_regRdData = overtempConfigTwo;
      `TFRC_ADDR_STEP_MC:
        next_regRdData = stepSizeMasterCpu;
      `TFRC_ADDR_STEP_SP:
        next_regRdData = stepSizeSensorPush;
      `TFRC_ADDR_CPU_ZERO:
        next_regRdData = cpuHeld[7:0];
      `TFRC_ADDR_CPU_ONE:
        next_regRdData = cpuHeld[15:8];
      `TFRC_ADDR_CPU_TWO:
        next_regRdData = cpuHeld[23:16];
      `TFRC_ADDR_CPU_THREE:
        next_regRdData = cpuHeld[31:24];
      `TFRC_ADDR_PART_ID:
        next_regRdData = PART_ID[7:0];
      `TFRC_ADDR_TERM_HI:
        next_regRdData = termHeld[9:2];
      `TFRC_ADDR_TERM_EXT:
        next_regRdData = {2'b00, termHeld[1:0], 4'h0};
      default:
        next_regRdData = 8'h00;
    endcase
  end

  // Read data held until the next read
  always @(posedge clk_sys)
  begin
    if (srst)
      regRdData <= 8'h00;
    else if (regRead)
      regRdData <= next_regRdData;
  end

  // ------------------------------------------------------------
  // Per-source over-temperature detection
  // ------------------------------------------------------------
  // Step size per source, slave sensors share the master field
  assign stepBus = {diodeSensorStepSize, cpuControlStepSize,
                    masterSensorStepSize, masterSensorStepSize,
                    pushedTempStepSize};
  assign srcEnable = {1'b1, 1'b1, 1'b1, slaveSensorSourceEnable,
                      pushedSourceEnable};

  genvar s;
  generate
    for (s = 0; s < 5; s = s + 1)
    begin : gSrc
      wire [7:0] temp;
      wire [7:0] limit;
      wire [8:0] limitPlusStep;
      assign temp = srcTemp[8*s+7:8*s];
      assign limit = srcLimit[8*s+7:8*s];
      assign limitPlusStep = {1'b0, limit} + {5'h00, stepBus[4*s+3:4*s]};
      // Source gated by its enable
      assign srcOver[s] = srcEnable[s] && (temp > limit);
      assign srcOverStep[s] = srcEnable[s] &&
                              ({1'b0, temp} > limitPlusStep);
    end
  endgenerate

  assign anyOver = |srcOver;
  assign anyOverStep = |srcOverStep;

  // ------------------------------------------------------------
  // Fan duty selection
  // ------------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < 3; f = f + 1)
    begin : gFan
      reg [7:0] next_duty;
      reg next_override;
      always @*
      begin
        next_duty = fanNormalDuty[8*f+7:8*f];
        next_override = 1'b0;
        if (anyOver && fanOvertempRespond[f])
        begin
          next_override = 1'b1;
          if (steppingEnable)
          begin
            if (anyOverStep)
              next_duty = second_step_level;
            else
              next_duty = first_step_level;
          end
          else if (fanFullSelect[f])
            next_duty = `TFRC_DUTY_FULL;
          else
            next_duty = fanMaxDuty[8*f+7:8*f];
        end
      end

      // Registered duty per fan
      always @(posedge clk_sys)
      begin
        if (srst)
        begin
          fanDuty[8*f+7:8*f] <= 8'h00;
          fanOverride[f] <= 1'b0;
        end
        else
        begin
          fanDuty[8*f+7:8*f] <= next_duty;
          fanOverride[f] <= next_override;
        end
      end
    end
  endgenerate

  // Any enabled source over its limit
  always @(posedge clk_sys)
  begin
    if (srst)
      overtempActive <= 1'b0;
    else
      overtempActive <= anyOver;
  end

  // ------------------------------------------------------------
  // Timer input pin selection
  // ------------------------------------------------------------
  tfrc_pin_sync uSyncA
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn(timerPinA),
    .pinOut(syncPinA)
  );

  tfrc_pin_sync uSyncB
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn(timerPinB),
    .pinOut(syncPinB)
  );

  tfrc_pin_sync uSyncC
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn(timerPinC),
    .pinOut(syncPinC)
  );

  // Selected pin drives the timer input, zero when disabled
  always @(posedge clk_sys)
  begin
    if (srst)
      timerInput <= 1'b0;
    else
    begin
      case (timerPinSelect)
        `TFRC_TMR_OFF:
          timerInput <= 1'b0;
        `TFRC_TMR_PIN_A:
          timerInput <= syncPinA;
        `TFRC_TMR_PIN_B:
          timerInput <= syncPinB;
        `TFRC_TMR_PIN_C:
          timerInput <= syncPinC;
        default:
          timerInput <= 1'b0;
      endcase
    end
  end

endmodule // tfrc_overtemp_signal_fan_config

// ### tfrc_overtemp_signal_fan_config_sva.sv
module tfrc_overtemp_signal_fan_config_sva
(
  input wire clk_sys,
  input wire srst,
  input wire [7:0] regAddr,
  input wire regRead,
  input wire [7:0] regRdData,
  input wire steppingEnable,
  input wire [23:0] fanNormalDuty,
  input wire [23:0] fanMaxDuty,
  input wire timerPinA,
  input wire timerPinB,
  input wire timerPinC,
  input wire [31:0] cpuReadings,
  input wire [23:0] fanDuty,
  input wire [2:0] fanOverride,
  input wire overtempActive,
  input wire timerInput
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Cycles with every timer pin low
  reg [3:0] lowCnt;
  always @(posedge clk_sys)
  begin
    if (srst | timerPinA | timerPinB | timerPinC)
      lowCnt <= 4'h0;
    else if (lowCnt != 4'hF)
      lowCnt <= lowCnt + 4'h1;
  end

  // ---------------------------------
  // Properties
  // ---------------------------------
  AST_CFG2_RSVD: assert property (regRead && regAddr == 8'h17
    |=> regRdData[7:3] == 5'h00) else $error("cfg two reserved bits set");
  AST_EXT_RSVD: assert property (regRead && regAddr == 8'h1F
    |=> {regRdData[7:6], regRdData[3:0]} == 6'h00)
    else $error("extended reserved bits set");
  AST_CPU_ONE: assert property (regRead && regAddr == 8'h1A
    && $stable(cpuReadings) && !$past(srst)
    |=> regRdData == $past(cpuReadings[15:8])) else $error("cpu one read");
  AST_CPU_ZERO: assert property (regRead && regAddr == 8'h33
    && $stable(cpuReadings) && !$past(srst)
    |=> regRdData == $past(cpuReadings[7:0])) else $error("cpu zero read");
  AST_OVR_ACTIVE: assert property (fanOverride != 3'h0
    |-> overtempActive) else $error("override without event");
  AST_NORMAL: assert property (!fanOverride[0] && !$past(srst)
    |-> fanDuty[7:0] == $past(fanNormalDuty[7:0]))
    else $error("fan one not at normal duty");
  AST_FULL_MAX: assert property (fanOverride[0] && !$past(srst)
    && !$past(steppingEnable) |-> fanDuty[7:0] == 8'hFF
    || fanDuty[7:0] == $past(fanMaxDuty[7:0])) else $error("fan one duty");
  AST_TIMER_IDLE: assert property (lowCnt >= 4'h8
    |-> !timerInput) else $error("timer input without pin");

  CV_EXT: cover property (regRead && regAddr == 8'h1F);
  CV_STEP: cover property (fanOverride[0] && steppingEnable);
  CV_TIMER: cover property ($rose(timerInput));
endmodule // tfrc_overtemp_signal_fan_config_sva

bind tfrc_overtemp_signal_fan_config tfrc_overtemp_signal_fan_config_sva i_tfrc_sva
(
  .clk_sys(clk_sys),
  .srst(srst),
  .regAddr(regAddr),
  .regRead(regRead),
  .regRdData(regRdData),
  .steppingEnable(steppingEnable),
  .fanNormalDuty(fanNormalDuty),
  .fanMaxDuty(fanMaxDuty),
  .timerPinA(timerPinA),
  .timerPinB(timerPinB),
  .timerPinC(timerPinC),
  .cpuReadings(cpuReadings),
  .fanDuty(fanDuty),
  .fanOverride(fanOverride),
  .overtempActive(overtempActive),
  .timerInput(timerInput)
);

// ### test_tfrc_overtemp_signal_fan_config.sv
module test_tfrc_overtemp_signal_fan_config;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_sys, srst, regWrite, regRead, steppingEnable, termValid;
  reg timerPinA, timerPinB, timerPinC, rdSeen;
  reg [7:0] regAddr, regWrData, d, c1, c2;
  reg [39:0] srcTemp, srcLimit;
  reg [23:0] fanNormalDuty, fanMaxDuty;
  reg [31:0] cpuReadings;
  reg [9:0] termResult, t;
  reg [2:0] m;
  wire [7:0] regRdData;
  wire [23:0] fanDuty;
  wire [2:0] fanOverride;
  wire overtempActive, timerInput;
  logic [7:0] expQ[$];
  logic [7:0] ra[10] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
    8'h1F, 8'h1E, 8'h20, 8'h1D};
  logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h1C, 8'h07, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h3C};
  logic [7:0] wm[6] = '{8'hFF, 8'hFF, 8'h7F, 8'h07, 8'hFF, 8'hFF};
  logic [7:0] ca[4] = '{8'h33, 8'h1A, 8'h1B, 8'h1C};
  logic [7:0] stp[5] = '{8'h07, 8'h03, 8'h03, 8'h05, 8'h02};
  integer seed = 32'hE253;
  int n_mismatch = 0;
  int checks_done = 0;
  int i, k;

  tfrc_overtemp_signal_fan_config #(.PART_ID(8'h3C)) i_tfrc_overtemp_signal_fan_config
  (
    .clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .steppingEnable(steppingEnable),
    .srcTemp(srcTemp), .srcLimit(srcLimit),
    .fanNormalDuty(fanNormalDuty), .fanMaxDuty(fanMaxDuty),
    .timerPinA(timerPinA), .timerPinB(timerPinB), .timerPinC(timerPinC),
    .cpuReadings(cpuReadings), .termResult(termResult),
    .termValid(termValid), .fanDuty(fanDuty), .fanOverride(fanOverride),
    .overtempActive(overtempActive), .timerInput(timerInput)
  );

  // ---------------------------------
  // Tasks
  // ---------------------------------
  task check(input logic [23:0] seen, input logic [23:0] want);
    checks_done++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    regAddr = a;
    regWrData = v;
    regWrite = 1'b1;
    cyc(1);
    regWrite = 1'b0;
    cyc(1);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    regAddr = a;
    regRead = 1'b1;
    cyc(1);
    regRead = 1'b0;
    cyc(1);
  endtask

  task term(input logic [9:0] v);
    termResult = v;
    termValid = 1'b1;
    cyc(1);
    termValid = 1'b0;
    cyc(1);
  endtask

  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Clock and read data monitor
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    rdSeen <= regRead;
  always @(negedge clk_sys)
    if (rdSeen === 1'b1)
      check({16'h0000, regRdData}, {16'h0000, expQ.pop_front()});

  // Watchdog
  initial
  begin
    cyc(5000);
    n_mismatch++;
    print_verdict;
  end

  // ---------------------------------
  // Main sequence
  // ---------------------------------
  initial
  begin
    srst = 1'b1;
    {regWrite, regRead, steppingEnable, termValid} = 4'h0;
    {timerPinA, timerPinB, timerPinC} = 3'h0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    srcLimit = {5{8'h80}};
    srcTemp = {5{8'h10}};
    fanNormalDuty = 24'($random(seed));
    fanMaxDuty = 24'($random(seed));
    cpuReadings = $random(seed);
    termResult = 10'h000;
    cyc(3);
    srst = 1'b0;
    cyc(1);
    // Reset values, RO write ignored, unmapped read
    wr(8'h1E, 8'hFF);
    for (i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    for (i = 0; i < 4; i++)
      rd(ca[i], cpuReadings[8*i +: 8]);
    for (i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      wr(ra[i], d);
      rd(ra[i], d & wm[i]);
    end
    // Freeze across extended and upper byte reads
    t = 10'($random(seed));
    term(t);
    rd(8'h1F, {2'b00, t[1:0], 4'h0});
    term(~t);
    rd(8'h1E, t[9:2]);
    term(~t);
    rd(8'h1E, ~t[9:2]);
    // Full or maximum duty, respond bits
    c1 = 8'($random(seed));
    c2 = 8'($random(seed));
    wr(8'h14, c1);
    wr(8'h15, c2);
    wr(8'h17, 8'h03);
    wr(8'h16, 8'h14);
    srcTemp[39:32] = 8'h90;
    cyc(3);
    check(fanDuty, {fanNormalDuty[23:16], fanMaxDuty[15:8], 8'hFF});
    check({21'h0, fanOverride}, 24'h000003);
    // Pushed and slave source enables
    for (k = 0; k < 2; k++)
    begin
      srcTemp = {5{8'h10}};
      srcTemp[8*k +: 8] = 8'hC0;
      wr(8'h16, 8'h14);
      cyc(2);
      check(fanDuty, fanNormalDuty);
      wr(8'h16, 8'h14 | (8'h20 << k));
      cyc(2);
      check({23'h0, overtempActive}, 24'h000001);
    end
    // Stepping per source at limit plus step and one above
    steppingEnable = 1'b1;
    wr(8'h18, 8'h53);
    wr(8'h19, 8'h72);
    wr(8'h16, 8'h74);
    for (k = 0; k < 10; k++)
    begin
      srcTemp = {5{8'h10}};
      srcTemp[8*(k/2) +: 8] = 8'h80 + stp[k/2] + 8'(k % 2);
      cyc(3);
      check(fanDuty, {fanNormalDuty[23:16], {2{k % 2 ? c2 : c1}}});
    end
    // Timer pin selection
    steppingEnable = 1'b0;
    for (k = 0; k < 4; k++)
    begin
      wr(8'h16, 8'h14 | 8'(k));
      m = (k == 0) ? 3'h0 : 3'h1 << (k - 1);
      {timerPinC, timerPinB, timerPinA} = ~m;
      cyc(10);
      check({23'h0, timerInput}, 24'h000000);
      {timerPinC, timerPinB, timerPinA} = m;
      cyc(10);
      check({23'h0, timerInput}, {23'h0, k != 0});
    end
    // Selected pin released again
    {timerPinC, timerPinB, timerPinA} = 3'h0;
    cyc(10);
    check({23'h0, timerInput}, 24'h000000);
    cyc(3);
    print_verdict;
  end
endmodule // test_tfrc_overtemp_signal_fan_config
